// File: rtl/tcs_divider.sv
// Divider that turns qualified cycles into a one-cycle enable pulse.
`timescale 1ns/1ps
`default_nettype none
module tcs_divider #(
  parameter int W = 6
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic en_in,
  input wire logic [W-1:0] div_in,
  output logic tick_out
);
  logic [W-1:0] count;
  wire last = (count >= (div_in - W'(1)));

  // Pulse on the last qualified cycle of each period.
  assign tick_out = en_in & last;

  // Count qualified cycles and wrap at the divisor.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      count <= '0;
    end else if (en_in) begin
      count <= last ? '0 : count + W'(1);
    end
  end
endmodule : tcs_divider
`default_nettype wire

// File: rtl/tcs_edge_sync.sv
// Two-stage synchroniser with an edge detector behind it.
`timescale 1ns/1ps
`default_nettype none
module tcs_edge_sync #(
  parameter bit FALL = 1'b1
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic pin_in,
  output logic edge_out
);
  logic sync_a;
  logic sync_b;
  logic prev;

  // Only the second stage and the delayed copy feed the detector.
  assign edge_out = FALL ? (prev & ~sync_b) : (~prev & sync_b);

  // Synchronise the pin and keep one older sample.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end
endmodule : tcs_edge_sync
`default_nettype wire

// File: rtl/tcs_params.svh
// Constants for the timer clock select block.
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH
`define TCS_ADDR_W 8
`define TCS_CTRL_INDEX 8'h8e
`define TCS_STAT_INDEX 8'h8f
`define TCS_CTRL_RESET 8'h00
`define TCS_BIT_T3H 7
`define TCS_BIT_T3L 6
`define TCS_BIT_T2H 5
`define TCS_BIT_T2L 4
`define TCS_BIT_T1 3
`define TCS_BIT_T0 2
`define TCS_PRE_HI 1
`define TCS_PRE_LO 0
`define TCS_PRE_DIV12 2'h0
`define TCS_PRE_DIV4 2'h1
`define TCS_PRE_DIV48 2'h2
`define TCS_PRE_EXT8 2'h3
`define TCS_DIV_W 6
`define TCS_DIV12 6'h0c
`define TCS_DIV4 6'h04
`define TCS_DIV48 6'h30
`define TCS_EXT_DIV 6'h08
`endif

// File: rtl/tcs_pkg.sv
// Types shared by the timer clock select block.
package tcs_pkg;
  // Timer-side configuration bits that steer clock choice.
  typedef struct packed {
    logic tmr0_count_mode;
    logic tmr1_count_mode;
    logic tmr2_ext_clock_choice;
    logic tmr3_ext_clock_choice;
    logic tmr2_split;
    logic tmr3_split;
  } tcs_tmr_cfg_t;
  // One-cycle count enables delivered to each timer byte.
  typedef struct packed {
    logic tmr0;
    logic tmr1;
    logic tmr2_low;
    logic tmr2_high;
    logic tmr3_low;
    logic tmr3_high;
  } tcs_ticks_t;
endpackage : tcs_pkg

// File: rtl/tcs_top.sv
// Timer clock select and prescaler with an Avalon-MM register port.
// Function
// RQ1 - Bit 7 clocks Timer 3 high byte
// RQ2 - Bit 6 clocks Timer 3 low byte
// RQ3 - Bit 5 clocks Timer 2 high byte
// RQ4 - Bit 4 clocks Timer 2 low byte
// RQ5 - Bit 3 picks system or prescaled for Timer 1
// RQ6 - Timer 1 counter mode overrides its select
// RQ7 - Bit 2 picks system or prescaled for Timer 0
// RQ8 - Timer 0 counter mode overrides its select
// RQ9 - Prescale codes divide by 12, 4, 48
// RQ10 - Code 11 uses synchronised external clock by 8
// RQ11 - Timers 2/3 alternate: sysclk/12 or external/8
// RQ12 - Counter mode counts input pin falling edges
// RQ13 - Timebases are one-cycle enables, one clock domain
// RQ14 - Control register clears to zero at reset
`timescale 1ns/1ps
`default_nettype none
`include "tcs_params.svh"
module tcs_top
  import tcs_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [`TCS_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire tcs_tmr_cfg_t tmr_cfg_in,
  input wire logic ext_clk_in,
  input wire logic tmr0_pin_in,
  input wire logic tmr1_pin_in,
  output tcs_ticks_t ticks_out
);
  logic [7:0] timer_clock_control;
  logic ext_rise;
  logic ext8_tick;
  logic sys12_tick;
  logic presc_sys_tick;
  logic t0_fall;
  logic t1_fall;
  logic [`TCS_DIV_W-1:0] presc_div;
  logic presc_tick;
  logic alt2_tick;
  logic alt3_tick;
  tcs_ticks_t next_ticks;
  logic [31:0] next_readdata;
  localparam int DIV_W = `TCS_DIV_W;
  logic [`TCS_DIV_W-1:0] ext_seen;

  // Named fields of the control register.
  wire tmr3_high_clk_sel = timer_clock_control[`TCS_BIT_T3H];
  wire tmr3_low_clk_sel = timer_clock_control[`TCS_BIT_T3L];
  wire tmr2_high_clk_sel = timer_clock_control[`TCS_BIT_T2H];
  wire tmr2_low_clk_sel = timer_clock_control[`TCS_BIT_T2L];
  wire tmr1_sysclk_sel = timer_clock_control[`TCS_BIT_T1];
  wire tmr0_sysclk_sel = timer_clock_control[`TCS_BIT_T0];
  wire [1:0] prescale_select = timer_clock_control[`TCS_PRE_HI:`TCS_PRE_LO];

  // Bus decode; a request is served once waitrequest has dropped.
  wire bus_req = avs_read_in | avs_write_in;
  wire hit_ctrl = (avs_address_in == `TCS_CTRL_INDEX);
  wire hit_stat = (avs_address_in == `TCS_STAT_INDEX);
  wire bus_done = bus_req & ~avs_waitrequest_out;
  wire ctrl_we = bus_done & avs_write_in & hit_ctrl & avs_byteenable_in[0];

  // Read data; the status word shows the live timer clocking state.
  assign next_readdata = hit_ctrl ? {24'h000000, timer_clock_control} :
                         hit_stat ? {26'h0000000, next_ticks} :
                         32'h00000000;

  // External clock is synchronised, then rising edges are counted by 8.
  tcs_edge_sync #(
    .FALL(1'b0)
  ) u_ext_sync (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .pin_in(ext_clk_in),
    .edge_out(ext_rise)
  );

  tcs_divider #(
    .W(`TCS_DIV_W)
  ) u_ext_div (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .en_in(ext_rise),
    .div_in(`TCS_EXT_DIV),
    .tick_out(ext8_tick)
  );

  // Fixed system clock divided by 12 for Timers 2 and 3.
  tcs_divider #(
    .W(`TCS_DIV_W)
  ) u_sys12_div (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .en_in(1'b1),
    .div_in(`TCS_DIV12),
    .tick_out(sys12_tick)
  );

  // Prescaler divisor chosen by the two-bit prescale field.
  assign presc_div = (prescale_select == `TCS_PRE_DIV4) ? `TCS_DIV4 :      // RQ9
                     (prescale_select == `TCS_PRE_DIV48) ? `TCS_DIV48 :    // RQ9
                     `TCS_DIV12;                                           // RQ9

  tcs_divider #(
    .W(`TCS_DIV_W)
  ) u_presc_div (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .en_in(1'b1),
    .div_in(presc_div),
    .tick_out(presc_sys_tick)
  );

  // Code 11 hands the prescaled enable to the synchronised external path.
  assign presc_tick = (prescale_select == `TCS_PRE_EXT8) ? ext8_tick :   // RQ10
                      presc_sys_tick;

  // Counter-mode pins are synchronised and their falling edges detected.
  tcs_edge_sync #(
    .FALL(1'b1)
  ) u_t0_sync (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .pin_in(tmr0_pin_in),
    .edge_out(t0_fall)
  );

  tcs_edge_sync #(
    .FALL(1'b1)
  ) u_t1_sync (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .pin_in(tmr1_pin_in),
    .edge_out(t1_fall)
  );

  // Alternate source of Timers 2 and 3 follows each external choice bit.
  assign alt2_tick = tmr_cfg_in.tmr2_ext_clock_choice ? ext8_tick : sys12_tick;  // RQ11
  assign alt3_tick = tmr_cfg_in.tmr3_ext_clock_choice ? ext8_tick : sys12_tick;  // RQ11

  // Per-timer enable selection; the system clock is an enable of every cycle.
  assign next_ticks.tmr0 = tmr_cfg_in.tmr0_count_mode ? t0_fall :        // RQ8 RQ12
                           (tmr0_sysclk_sel | presc_tick);               // RQ7
  assign next_ticks.tmr1 = tmr_cfg_in.tmr1_count_mode ? t1_fall :        // RQ6 RQ12
                           (tmr1_sysclk_sel | presc_tick);               // RQ5
  assign next_ticks.tmr2_low = tmr2_low_clk_sel | alt2_tick;             // RQ4
  assign next_ticks.tmr2_high = tmr_cfg_in.tmr2_split &
                                (tmr2_high_clk_sel | alt2_tick);         // RQ3
  assign next_ticks.tmr3_low = tmr3_low_clk_sel | alt3_tick;             // RQ2
  assign next_ticks.tmr3_high = tmr_cfg_in.tmr3_split &
                                (tmr3_high_clk_sel | alt3_tick);         // RQ1

  // Register the enables so every timer sees a clean one-cycle pulse.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ticks_out <= '0;
    end else begin
      ticks_out <= next_ticks;  // RQ13
    end
  end

  // Control register write on the cycle the bus transfer completes.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      timer_clock_control <= `TCS_CTRL_RESET;  // RQ14
    end else if (ctrl_we) begin
      timer_clock_control <= avs_writedata_in[7:0];
    end
  end

  // One wait cycle per access; read data is loaded as waitrequest drops.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h00000000;
    end else begin
      avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
      if (bus_req & avs_waitrequest_out) begin
        avs_readdata_out <= next_readdata;
      end
    end
  end

  // Checks of the selection behaviour.
  property p_t0_sys;
    @(posedge ref_clk_in) disable iff (reset_in)
    (tmr0_sysclk_sel && !tmr_cfg_in.tmr0_count_mode) |=> ticks_out.tmr0;
  endproperty
  a_t0_sys: assert property (p_t0_sys) else $error("Timer 0 missed sysclk enable"); // RQ7

  property p_t1_sys;
    @(posedge ref_clk_in) disable iff (reset_in)
    (tmr1_sysclk_sel && !tmr_cfg_in.tmr1_count_mode) |=> ticks_out.tmr1;
  endproperty
  a_t1_sys: assert property (p_t1_sys) else $error("Timer 1 missed sysclk enable"); // RQ5

  property p_t0_cnt;
    @(posedge ref_clk_in) disable iff (reset_in)
    tmr_cfg_in.tmr0_count_mode |=> (ticks_out.tmr0 == $past(t0_fall));
  endproperty
  a_t0_cnt: assert property (p_t0_cnt) else $error("Timer 0 counter mode wrong"); // RQ8

  property p_t1_cnt;
    @(posedge ref_clk_in) disable iff (reset_in)
    tmr_cfg_in.tmr1_count_mode |=> (ticks_out.tmr1 == $past(t1_fall));
  endproperty
  a_t1_cnt: assert property (p_t1_cnt) else $error("Timer 1 counter mode wrong"); // RQ6

  property p_fall_only;
    @(posedge ref_clk_in) disable iff (reset_in)
    t0_fall |=> !t0_fall;
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("Pin edge not single"); // RQ12

  property p_div4;
    @(posedge ref_clk_in) disable iff (reset_in)
    (presc_tick && prescale_select == `TCS_PRE_DIV4) |=>
      (!presc_tick || prescale_select != `TCS_PRE_DIV4)[*3];
  endproperty
  a_div4: assert property (p_div4) else $error("Divide by 4 too fast"); // RQ9

  property p_div12;
    @(posedge ref_clk_in) disable iff (reset_in)
    (presc_tick && prescale_select == `TCS_PRE_DIV12) |=>
      (!presc_tick || prescale_select != `TCS_PRE_DIV12)[*8];
  endproperty
  a_div12: assert property (p_div12) else $error("Divide by 12 too fast"); // RQ9

  property p_ext8;
    @(posedge ref_clk_in) disable iff (reset_in)
    (prescale_select == `TCS_PRE_EXT8 && presc_tick) |-> ext_rise;
  endproperty
  a_ext8: assert property (p_ext8) else $error("External tick without edge"); // RQ10

  property p_alt2;
    @(posedge ref_clk_in) disable iff (reset_in)
    (!tmr2_low_clk_sel && !tmr_cfg_in.tmr2_ext_clock_choice) |=>
      (ticks_out.tmr2_low == $past(sys12_tick));
  endproperty
  a_alt2: assert property (p_alt2) else $error("Timer 2 alternate wrong"); // RQ11 RQ4

  property p_t2h;
    @(posedge ref_clk_in) disable iff (reset_in)
    (tmr2_high_clk_sel && tmr_cfg_in.tmr2_split) |=> ticks_out.tmr2_high;
  endproperty
  a_t2h: assert property (p_t2h) else $error("Timer 2 high sysclk missed"); // RQ3

  property p_t3l;
    @(posedge ref_clk_in) disable iff (reset_in)
    tmr3_low_clk_sel |=> ticks_out.tmr3_low;
  endproperty
  a_t3l: assert property (p_t3l) else $error("Timer 3 low sysclk missed"); // RQ2

  property p_t3h;
    @(posedge ref_clk_in) disable iff (reset_in)
    !tmr_cfg_in.tmr3_split |=> !ticks_out.tmr3_high;
  endproperty
  a_t3h: assert property (p_t3h) else $error("Timer 3 high ticks unsplit"); // RQ1

  property p_pulse;
    @(posedge ref_clk_in) disable iff (reset_in)
    ext8_tick |=> !ext8_tick;
  endproperty
  a_pulse: assert property (p_pulse) else $error("Enable wider than a cycle"); // RQ13

  property p_reset;
    @(posedge ref_clk_in) disable iff (reset_in)
    $past(reset_in) |-> (timer_clock_control == `TCS_CTRL_RESET);
  endproperty
  a_reset: assert property (p_reset) else $error("Control not clear after reset"); // RQ14

  // Rising external edges since the last divided tick; this feeds a check only.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ext_seen <= '0;
    end else if (ext8_tick) begin
      ext_seen <= '0;
    end else if (ext_rise) begin
      ext_seen <= ext_seen + DIV_W'(1);
    end
  end

  property p_ext_period;
    @(posedge ref_clk_in) disable iff (reset_in)
    ext8_tick |-> (ext_seen == (`TCS_EXT_DIV - DIV_W'(1)));
  endproperty
  a_ext_period: assert property (p_ext_period) else $error("External divide wrong"); // RQ10

  property p_t2h_off;
    @(posedge ref_clk_in) disable iff (reset_in)
    !tmr_cfg_in.tmr2_split |=> !ticks_out.tmr2_high;
  endproperty
  a_t2h_off: assert property (p_t2h_off) else $error("Timer 2 high ticks unsplit"); // RQ3

  // Main scenarios worth seeing.
  c_div48: cover property (@(posedge ref_clk_in) disable iff (reset_in)
    prescale_select == `TCS_PRE_DIV48 && presc_tick);
  c_ext_t2: cover property (@(posedge ref_clk_in) disable iff (reset_in)
    tmr_cfg_in.tmr2_ext_clock_choice && ext8_tick);
  c_count0: cover property (@(posedge ref_clk_in) disable iff (reset_in)
    tmr_cfg_in.tmr0_count_mode && t0_fall);
endmodule : tcs_top
`default_nettype wire

// File: tb/tcs_top_tb_top.sv
// Self-checking testbench for the timer clock select block.
`timescale 1ns/1ps
`default_nettype none
`include "tcs_params.svh"
module tcs_top_tb_top;
  import tcs_pkg::*;
  logic ref_clk;
  logic rst;
  logic [7:0] addr;
  logic rd_req;
  logic wr_req;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic waitreq;
  tcs_tmr_cfg_t cfg;
  logic ext_clk;
  logic ext_run;
  logic [1:0] ext_div;
  logic pin0;
  logic pin1;
  tcs_ticks_t ticks;
  wire logic [5:0] tk;
  int err_count;
  int checks;
  int cnt [6];
  logic [31:0] rd_val;

  assign tk = ticks;

  tcs_top u_dut (
    .ref_clk_in(ref_clk),
    .reset_in(rst),
    .avs_address_in(addr),
    .avs_read_in(rd_req),
    .avs_write_in(wr_req),
    .avs_writedata_in(wdata),
    .avs_byteenable_in(be),
    .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq),
    .tmr_cfg_in(cfg),
    .ext_clk_in(ext_clk),
    .tmr0_pin_in(pin0),
    .tmr1_pin_in(pin1),
    .ticks_out(ticks)
  );

  // System clock of 25 ns.
  always #12.5 ref_clk = ~ref_clk;

  // External clock of four system cycles, running only while enabled.
  always @(posedge ref_clk) begin
    ext_div <= ext_div + 2'h1;
    ext_clk <= ext_run & ext_div[1];
  end

  // Compares a seen value with the expected one and counts both.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One bus access held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] en);
    int n;
    n = 0;
    @(posedge ref_clk);
    addr <= a;
    rd_req <= ~wr;
    wr_req <= wr;
    wdata <= d;
    be <= en;
    forever begin
      @(posedge ref_clk);
      if (waitreq === 1'b0) break;
      n++;
      if (n > 50) begin
        chk(32'h1, 32'h0);
        break;
      end
    end
    rd_val = rdata;
    rd_req <= 1'b0;
    wr_req <= 1'b0;
  endtask : bus

  // Counts the ticks of every timer byte over a window.
  task automatic count_win(input int settle, input int ncyc);
    repeat (settle) @(posedge ref_clk);
    foreach (cnt[i]) cnt[i] = 0;
    repeat (ncyc) begin
      @(posedge ref_clk);
      for (int i = 0; i < 6; i++) begin
        if (tk[i] === 1'b1) cnt[i]++;
      end
    end
  endtask : count_win

  // Reset value, refused writes and unmapped reads.
  task automatic t_regs();
    count_win(16, 96);
    chk(cnt[5], 8);
    bus(1'b0, `TCS_CTRL_INDEX, 32'h0, 4'hf);
    chk(rd_val, {24'h0, `TCS_CTRL_RESET});
    bus(1'b1, `TCS_CTRL_INDEX, 32'h0000_00a5, 4'he);
    bus(1'b1, 8'h10, 32'h0000_0033, 4'hf);
    bus(1'b0, 8'h10, 32'h0, 4'hf);
    chk(rd_val, 32'h0);
    bus(1'b0, `TCS_CTRL_INDEX, 32'h0, 4'hf);
    chk(rd_val, 32'h0);
    bus(1'b1, `TCS_CTRL_INDEX, 32'hffff_ff5a, 4'hf);
    bus(1'b0, `TCS_CTRL_INDEX, 32'h0, 4'hf);
    chk(rd_val, 32'h0000_005a);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, `TCS_CTRL_INDEX, 32'h0, 4'hf);
    chk(rd_val, {24'h0, `TCS_CTRL_RESET});
  endtask : t_regs

  // Every prescale code on Timers 0 and 1.
  task automatic t_prescale();
    int exp [3] = '{8, 24, 2};
    for (int c = 0; c < 3; c++) begin
      bus(1'b1, `TCS_CTRL_INDEX, 32'(c), 4'h1);
      count_win(64, 96);
      chk(cnt[5], exp[c]);
      chk(cnt[4], exp[c]);
    end
    ext_run <= 1'b1;
    bus(1'b1, `TCS_CTRL_INDEX, {30'h0, `TCS_PRE_EXT8}, 4'h1);
    count_win(64, 96);
    chk(cnt[5], 3);
    chk(cnt[4], 3);
  endtask : t_prescale

  // System clock selection and the counter-mode override.
  task automatic t_sysclk();
    bus(1'b1, `TCS_CTRL_INDEX, 32'h0000_0008, 4'h1);
    count_win(64, 96);
    chk(cnt[4], 96);
    chk(cnt[5], 8);
    bus(1'b1, `TCS_CTRL_INDEX, 32'h0000_000c, 4'h1);
    count_win(8, 96);
    chk(cnt[5], 96);
    cfg.tmr0_count_mode <= 1'b1;
    cfg.tmr1_count_mode <= 1'b1;
    count_win(8, 48);
    chk(cnt[5], 0);
    chk(cnt[4], 0);
    pin0 <= 1'b0;
    pin1 <= 1'b0;
    count_win(0, 12);
    chk(cnt[5], 1);
    chk(cnt[4], 1);
    pin0 <= 1'b1;
    pin1 <= 1'b1;
    count_win(0, 12);
    chk(cnt[5], 0);
    chk(cnt[4], 0);
    cfg.tmr0_count_mode <= 1'b0;
    cfg.tmr1_count_mode <= 1'b0;
  endtask : t_sysclk

  // Byte selects of Timers 2 and 3 and their alternate sources.
  task automatic t_t23();
    cfg.tmr2_split <= 1'b1;
    cfg.tmr3_split <= 1'b1;
    bus(1'b1, `TCS_CTRL_INDEX, 32'h0000_0000, 4'h1);
    count_win(64, 96);
    for (int i = 0; i < 4; i++) chk(cnt[i], 8);
    bus(1'b1, `TCS_CTRL_INDEX, 32'h0000_00f0, 4'h1);
    count_win(8, 96);
    for (int i = 0; i < 4; i++) chk(cnt[i], 96);
    cfg.tmr2_split <= 1'b0;
    cfg.tmr3_split <= 1'b0;
    count_win(8, 96);
    chk(cnt[0], 0);
    chk(cnt[2], 0);
    chk(cnt[1], 96);
    chk(cnt[3], 96);
    cfg.tmr2_split <= 1'b1;
    cfg.tmr3_split <= 1'b1;
    cfg.tmr2_ext_clock_choice <= 1'b1;
    cfg.tmr3_ext_clock_choice <= 1'b1;
    bus(1'b1, `TCS_CTRL_INDEX, 32'h0000_00a0, 4'h1);
    count_win(64, 96);
    chk(cnt[0], 96);
    chk(cnt[2], 96);
    chk(cnt[1], 3);
    chk(cnt[3], 3);
    bus(1'b1, `TCS_CTRL_INDEX, 32'h0000_00fc, 4'h1);
    bus(1'b0, `TCS_STAT_INDEX, 32'h0, 4'hf);
    chk(rd_val, 32'h0000_003f);
    bus(1'b1, `TCS_STAT_INDEX, 32'h0, 4'hf);
    bus(1'b0, `TCS_CTRL_INDEX, 32'h0, 4'hf);
    chk(rd_val, 32'h0000_00fc);
  endtask : t_t23

  // Prints the verdict and ends the run.
  task automatic results();
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // Main sequence: reset for 16 cycles, then every scenario.
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    addr = 8'h00;
    rd_req = 1'b0;
    wr_req = 1'b0;
    wdata = 32'h0;
    be = 4'h0;
    cfg = '0;
    ext_clk = 1'b0;
    ext_run = 1'b0;
    ext_div = 2'h0;
    pin0 = 1'b1;
    pin1 = 1'b1;
    err_count = 0;
    checks = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_prescale();
    t_sysclk();
    t_t23();
    results();
  end

  // Watchdog well beyond the roughly 1700 cycles the scenarios need.
  initial begin
    #(25 * 20000);
    err_count++;
    results();
  end
endmodule : tcs_top_tb_top
`default_nettype wire
